//--- rtl/vfa_map.svh
// Offsets, field positions, reset values and widths of the failing-address capture block.
//=============================================================
// Notes on behaviour
// - Read-only failing address word at offset 0x48.
// - Address valid only after own-master timeout flagged.
// - LWORD bit tracks cycles, locks at timeout.
// - Low LWORD line is stored as one.
`ifndef VFA_MAP_SVH
`define VFA_MAP_SVH

//=============================================================
// Register map
`define VFA_OFFSET_W        8
`define VFA_FAIL_ADDR_OFS   8'h48

//=============================================================
// Field layout of the failing address word
`define VFA_ADDR_MSB        31
`define VFA_ADDR_LSB        1
`define VFA_ADDR_W          31
`define VFA_LWORD_BIT       0

//=============================================================
// Reset values and read answers
`define VFA_ADDR_RESET      31'h0000_0000
`define VFA_LWORD_RESET     1'h0
`define VFA_UNMAPPED_DATA   32'h0000_0000

`endif

//--- rtl/vfa_pkg.sv
// Types shared by the failing-address capture block.
package vfa_pkg;

    //=========================================================
    // Data types
    typedef logic [30:0] vfa_addr_t;   // Address lines A01 to A31.
    typedef logic [31:0] vfa_word_t;   // One register word.
    typedef logic [7:0]  vfa_ofs_t;    // Nodespace register offset.

endpackage

//--- rtl/vfa_pin_filter.sv
// Three-stage pin synchroniser with agreement filter for a group of bus lines.
`timescale 1ns/1ps
module vfa_pin_filter
#(
    parameter int WIDTH = 32
)
(
    // Clock and reset.
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // Raw pins and accepted level.
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    //=========================================================
    // Per-line synchroniser and filter
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1)
        begin : g_line
            logic s1_reg;   // First stage, read only by the second.
            logic s2_reg;   // Second stage.
            logic s3_reg;   // Third stage.
            logic lv_reg;   // Accepted level.

            // A change counts only when stages two and three agree, which rejects one-cycle glitches.
            always_ff @(posedge clk_in)
            begin
                if (reset_in)
                begin
                    s1_reg <= 1'h0;
                    s2_reg <= 1'h0;
                    s3_reg <= 1'h0;
                    lv_reg <= 1'h0;
                end
                else
                begin
                    s1_reg <= pin_in[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg)
                    begin
                        lv_reg <= s3_reg;
                    end
                end
            end

            assign level_out[gi] = lv_reg;
        end
    endgenerate

endmodule

//--- rtl/vfa_capture.sv
// Failing VMEbus address capture register with timeout freeze and nodespace read port.
`timescale 1ns/1ps
`include "vfa_map.svh"
module vfa_capture
import vfa_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // VMEbus pins, asynchronous to the adapter clock.
    input  wire logic [30:0] vme_addr_in,
    input  wire logic        vme_lword_n_in,
    // Timeout and error status from adapter logic on the same clock.
    input  wire logic        timeout_in,
    input  wire logic        timeout_flag_in,
    input  wire logic        vme_master_in,
    // Nodespace read port.
    input  wire logic        rd_en_in,
    input  wire logic [7:0]  rd_offset_in,
    output logic      [31:0] rd_data_out,
    output logic             rd_ack_out,
    // Capture status.
    output logic             frozen_out,
    output logic             capture_valid_out
);

    //=========================================================
    // Pin synchronisation
    logic [31:0] pins_raw;      // Address lines with LWORD* in bit 0, one meaning asserted.
    logic [31:0] pins_level;    // Filtered pin levels.
    vfa_addr_t   addr_level;    // Filtered address lines.
    logic        lword_level;   // Filtered LWORD*, one means asserted.

    // LWORD* is turned round before the filter. The filter clears to zero, and zero must mean the
    // idle, deasserted line, or the first cycles after a reset would show a false LWORD.
    assign pins_raw    = {vme_addr_in, ~vme_lword_n_in};
    assign addr_level  = pins_level[`VFA_ADDR_MSB:`VFA_ADDR_LSB];
    assign lword_level = pins_level[`VFA_LWORD_BIT];

    // One filter for all lines keeps the address and LWORD* at equal latency.
    vfa_pin_filter #(
        .WIDTH     (32)
    ) u_pins (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .pin_in    (pins_raw),
        .level_out (pins_level)
    );

    //=========================================================
    // State registers
    vfa_addr_t addr_reg;        // Captured address lines.
    logic      lword_reg;       // Captured LWORD*, one means asserted.
    logic      frozen_reg;      // Snapshot locked by a timeout.
    logic      frozen_next;     // Next lock state.
    logic      master_reg;      // Adapter was master at the locking timeout.
    logic      master_next;     // Next master record.
    logic      flag_reg;        // Timeout flag seen last cycle.
    logic      flag_fall;       // Software has just cleared the timeout flag.
    logic      valid_reg;       // Captured address is meaningful.
    logic      valid_next;      // Next validity.
    logic      take_timeout;    // A timeout locks the snapshot this edge.
    logic      track;           // Snapshot follows the bus this edge.

    //=========================================================
    // Freeze control
    // The flag falls only through a software clear, so its falling edge is the release point.
    assign flag_fall    = flag_reg & ~timeout_flag_in;
    // A timeout while already locked is ignored, so the first failure stays on view.
    assign take_timeout = timeout_in & ~frozen_reg;
    // The edge of the timeout still loads, so the value present at the timeout is kept.
    assign track        = ~frozen_reg;
    // A timeout in the very cycle of the clear wins and locks again.
    assign frozen_next  = timeout_in | (frozen_reg & ~flag_fall);
    assign master_next  = take_timeout ? vme_master_in : (master_reg & frozen_next);
    // Valid needs the lock, own mastership and the flag still set.
    assign valid_next   = frozen_next & master_next & timeout_flag_in;

    // Lock state, master record and validity.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            frozen_reg <= 1'h0;
            master_reg <= 1'h0;
            flag_reg   <= 1'h0;
            valid_reg  <= 1'h0;
        end
        else
        begin
            frozen_reg <= frozen_next;
            master_reg <= master_next;
            flag_reg   <= timeout_flag_in;
            valid_reg  <= valid_next;
        end
    end

    //=========================================================
    // Snapshot
    // The address has no defined reset value; clearing it anyway costs nothing and aids debug.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            addr_reg  <= `VFA_ADDR_RESET;
            lword_reg <= `VFA_LWORD_RESET;
        end
        else if (track)
        begin
            addr_reg  <= addr_level;
            lword_reg <= lword_level;
        end
    end

    //=========================================================
    // Nodespace read port
    logic      rd_hit;        // Read addresses the failing address word.
    vfa_word_t rd_word;       // Word answered to this read.
    vfa_word_t rd_data_reg;   // Registered read data.
    logic      rd_ack_reg;    // Registered read acknowledge.

    assign rd_hit  = rd_offset_in == `VFA_FAIL_ADDR_OFS;
    // Unmapped offsets answer with zero so a stray read is still acknowledged.
    assign rd_word = rd_hit ? {addr_reg, lword_reg} : `VFA_UNMAPPED_DATA;

    // One-cycle read answer; data holds until the next read.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            rd_data_reg <= `VFA_UNMAPPED_DATA;
            rd_ack_reg  <= 1'h0;
        end
        else
        begin
            rd_ack_reg <= rd_en_in;
            if (rd_en_in)
            begin
                rd_data_reg <= rd_word;
            end
        end
    end

    //=========================================================
    // Outputs
    assign rd_data_out       = rd_data_reg;
    assign rd_ack_out        = rd_ack_reg;
    assign frozen_out        = frozen_reg;
    assign capture_valid_out = valid_reg;

    //=========================================================
    // Assertions
    // A timeout taken while tracking, seen over its two steps.
    sequence s_timeout_taken;
        timeout_in && !frozen_reg;
    endsequence

    sequence s_locked_after;
        frozen_reg && (lword_reg == $past(lword_level)) && (addr_reg == $past(addr_level));
    endsequence

    property p_read_hit;
        @(posedge clk_in) disable iff (reset_in)
        rd_en_in && rd_hit |=> rd_ack_out && (rd_data_out == {$past(addr_reg), $past(lword_reg)});
    endproperty
    a_read_hit: assert property (p_read_hit) else $error("failing address read returned wrong word");

    property p_read_miss;
        @(posedge clk_in) disable iff (reset_in)
        rd_en_in && !rd_hit |=> rd_ack_out && (rd_data_out == 32'h0000_0000);
    endproperty
    a_read_miss: assert property (p_read_miss) else $error("unmapped read did not return zero");

    property p_valid_gate;
        @(posedge clk_in) disable iff (reset_in)
        capture_valid_out |-> frozen_reg && master_reg && $past(timeout_flag_in);
    endproperty
    a_valid_gate: assert property (p_valid_gate) else $error("capture valid without master timeout");

    property p_freeze_step;
        @(posedge clk_in) disable iff (reset_in)
        s_timeout_taken |=> s_locked_after;
    endproperty
    a_freeze_step: assert property (p_freeze_step) else $error("timeout did not lock the present value");

    property p_hold;
        @(posedge clk_in) disable iff (reset_in)
        frozen_reg && !flag_fall |=> frozen_reg && $stable(addr_reg) && $stable(lword_reg) [*1];
    endproperty
    a_hold: assert property (p_hold) else $error("locked snapshot changed");

    property p_polarity;
        @(posedge clk_in) disable iff (reset_in)
        !frozen_reg ##1 !frozen_reg |-> lword_reg == $past(lword_level);
    endproperty
    a_polarity: assert property (p_polarity) else $error("LWORD level stored with wrong sense");

    property p_resume;
        @(posedge clk_in) disable iff (reset_in)
        frozen_reg && flag_fall && !timeout_in |=> !frozen_reg ##1 (addr_reg == $past(addr_level));
    endproperty
    a_resume: assert property (p_resume) else $error("snapshot did not resume after flag clear");

    // A timeout always leaves the snapshot locked, even when it meets a flag clear.
    property p_lock_on_timeout;
        @(posedge clk_in) disable iff (reset_in)
        timeout_in |=> frozen_reg;
    endproperty
    a_lock_on_timeout: assert property (p_lock_on_timeout) else $error("timeout did not lock the snapshot");

    // A later timeout while locked must not rewrite the master record of the first one.
    property p_master_kept;
        @(posedge clk_in) disable iff (reset_in)
        frozen_reg && !flag_fall |=> $stable(master_reg);
    endproperty
    a_master_kept: assert property (p_master_kept) else $error("master record changed while locked");

    // The acknowledge is the strobe delayed by one cycle: no strobe, no answer.
    property p_ack_pulse;
        @(posedge clk_in) disable iff (reset_in)
        !rd_en_in |=> !rd_ack_out;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("read acknowledged without a strobe");

    // Read data stands until the next read, so a slow reader still sees its word.
    property p_data_hold;
        @(posedge clk_in) disable iff (reset_in)
        !rd_en_in |=> $stable(rd_data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data changed without a read");

endmodule

//--- bench/vfa_vme_slave.sv
// Behavioural VMEbus far side: shows the address lines and flags an unanswered cycle.
`timescale 1ns/1ps
module vfa_vme_slave
#(
    parameter int WAIT_CYC = 8
)
(
    // Clock.
    input  wire logic        clk_in,
    // Cycle request from the bench.
    input  wire logic        cyc_in,
    input  wire logic        answer_in,
    input  wire logic [30:0] addr_in,
    input  wire logic        lword_n_in,
    // Bus lines and timeout pulse.
    output logic      [30:0] pin_addr_out,
    output logic             pin_lword_n_out,
    output logic             timeout_out
);
    //=========================================================
    // State
    logic [7:0]  wait_reg = 8'h00;   // Cycles spent without an answer.
    logic [31:0] last_reg = 32'h0;   // Last value shown on the lines.

    // Count the wait, and remember the lines while a cycle is on.
    always_ff @(posedge clk_in)
    begin
        wait_reg <= (cyc_in && !answer_in) ? wait_reg + 8'h01 : 8'h00;
        if (cyc_in)
            last_reg <= {addr_in, lword_n_in};
    end

    // Released lines show the inverse of the last value so that stale data never looks held.
    assign {pin_addr_out, pin_lword_n_out} = cyc_in ? {addr_in, lword_n_in} : ~last_reg;
    // A slave that never answers leaves a one-cycle timeout pulse behind.
    assign timeout_out = cyc_in && !answer_in && (wait_reg == 8'(WAIT_CYC));
endmodule

//--- bench/vme_failing_address_capture_test.sv
// Self-checking bench for the failing-address capture block.
`timescale 1ns/1ps
`include "vfa_map.svh"
module vme_failing_address_capture_test;
    //=========================================================
    // Signals
    logic        clk_in = 1'b0;     // 40 MHz clock.
    logic        reset_in = 1'b1;   // Synchronous reset.
    logic        cyc = 1'b0;        // Bus cycle in progress.
    logic        answer = 1'b1;     // Slave answers the cycle.
    logic [30:0] addr = 31'h0;      // Address put on the bus.
    logic        lword_n = 1'b1;    // Line level put on the bus.
    logic        flag = 1'b0;       // Timeout status flag.
    logic        master = 1'b0;     // Adapter owns the bus.
    logic        rd_en = 1'b0;      // Read strobe.
    logic [7:0]  rd_offset = 8'h0;  // Read offset.
    logic [30:0] pin_addr;          // Address lines.
    logic        pin_lword_n;       // Long-word line.
    logic        timeout;           // Timeout pulse.
    logic [31:0] rd_data;           // Read answer.
    logic        rd_ack;            // Read acknowledge.
    logic        frozen;            // Snapshot locked.
    logic        cap_valid;         // Capture meaningful.
    int          error_cnt = 0;     // Mismatches.
    int          cmp_count = 0;     // Comparisons.
    int          cyc_cnt = 0;       // Watchdog count.

    always #12.5 clk_in = ~clk_in;

    vfa_vme_slave u_slave (.clk_in(clk_in), .cyc_in(cyc), .answer_in(answer), .addr_in(addr),
        .lword_n_in(lword_n), .pin_addr_out(pin_addr), .pin_lword_n_out(pin_lword_n), .timeout_out(timeout));

    vfa_capture u_dut (.clk_in(clk_in), .reset_in(reset_in), .vme_addr_in(pin_addr),
        .vme_lword_n_in(pin_lword_n), .timeout_in(timeout), .timeout_flag_in(flag), .vme_master_in(master),
        .rd_en_in(rd_en), .rd_offset_in(rd_offset), .rd_data_out(rd_data), .rd_ack_out(rd_ack),
        .frozen_out(frozen), .capture_valid_out(cap_valid));

    //=========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One read; the answer is due exactly one cycle after the strobe.
    task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
        @(negedge clk_in);
        rd_en = 1'b1;
        rd_offset = ofs;
        @(negedge clk_in);
        rd_en = 1'b0;
        check({31'h0, rd_ack}, 32'h1);
        check(rd_data, exp);
    endtask

    // A bus cycle: tracked while on, then the lines are released.
    task automatic bus_cycle(input logic [30:0] a, input logic lw_n, input logic ans);
        @(negedge clk_in);
        addr = a;
        lword_n = lw_n;
        answer = ans;
        cyc = 1'b1;
        repeat (6) @(negedge clk_in);
        rd(`VFA_FAIL_ADDR_OFS, {a, ~lw_n});
        repeat (4) @(negedge clk_in);
        cyc = 1'b0;
        repeat (7) @(negedge clk_in);
        if (ans)
            rd(`VFA_FAIL_ADDR_OFS, {~a, lw_n});
        else
            rd(`VFA_FAIL_ADDR_OFS, {a, ~lw_n});
    endtask

    //=========================================================
    // Scenarios
    task automatic t_reset();
        rd(`VFA_FAIL_ADDR_OFS, 32'h0);
        rd(8'h4c, 32'h0);
    endtask

    // Timeout locks the first failure; clearing the flag resumes tracking.
    task automatic t_timeout(input logic [30:0] a, input logic lw_n, input logic m);
        master = m;
        bus_cycle(a, lw_n, 1'b0);
        flag = 1'b1;
        repeat (3) @(negedge clk_in);
        check({31'h0, frozen}, 32'h1);
        check({31'h0, cap_valid}, {31'h0, m});
        rd(`VFA_FAIL_ADDR_OFS, {a, ~lw_n});
        flag = 1'b0;
        repeat (3) @(negedge clk_in);
        check({30'h0, frozen, cap_valid}, 32'h0);
        repeat (6) @(negedge clk_in);
        rd(`VFA_FAIL_ADDR_OFS, {~a, lw_n});
    endtask

    // A reset in mid-run clears the LWORD bit although the released line shows it asserted.
    task automatic t_mid_reset();
        @(negedge clk_in);
        reset_in = 1'b1;
        repeat (4) @(negedge clk_in);
        reset_in = 1'b0;
        check({29'h0, frozen, cap_valid, rd_ack}, 32'h0);
        rd(`VFA_FAIL_ADDR_OFS, 32'h0);
        repeat (4) @(negedge clk_in);
        rd(`VFA_FAIL_ADDR_OFS, {31'h7fff_fffe, 1'b1});
    endtask

    //=========================================================
    // Watchdog and closing
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // The whole run takes about 130 cycles, so 2000 is ample.
    always @(posedge clk_in)
    begin
        cyc_cnt++;
        if (cyc_cnt == 2000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (12) @(negedge clk_in);
        reset_in = 1'b0;
        t_reset();
        bus_cycle(31'h2aaa_5555, 1'b0, 1'b1);
        t_timeout(31'h7fff_ffff, 1'b0, 1'b1);
        t_timeout(31'h0000_0001, 1'b1, 1'b0);
        t_mid_reset();
        wrap_up();
    end
endmodule
